/* include/mixer_routing_consts.svh */
`ifndef MIXER_ROUTING_CONSTS_SVH
`define MIXER_ROUTING_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_MIC_BIAS_BUTTON   8'h0C
`define OFS_SIDETONE          8'h0D
`define OFS_PHONE_INPUT       8'h0E
`define OFS_LEFT_LINE_INPUT   8'h0F
`define OFS_RIGHT_LINE_INPUT  8'h10
`define OFS_CONVERTER_LEVEL   8'h11
`define OFS_PHONE_OUTPUT      8'h12
`define OFS_LINE_OUTPUT       8'h13
`define OFS_SPEAKER_OUTPUT    8'h14

// ----------------------------------------
// implemented-bit masks and reset value
// ----------------------------------------
`define MASK_MIC_BIAS_BUTTON  8'h3F
`define MASK_SIDETONE         8'h0F
`define MASK_PHONE_INPUT      8'h3F
`define MASK_LINE_INPUT       8'hFF
`define MASK_CONVERTER        8'hFF
`define MASK_PHONE_OUTPUT     8'h1F
`define MASK_LINE_OUTPUT      8'h0F
`define MASK_SPEAKER_OUTPUT   8'h0F
`define REG_RESET             8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_VCM_SEL           0
`define BIT_BUTTON_SERIES     3
`define BIT_BOOST             5
`define BIT_MUTE_IN           6
`define BIT_SRC_SEL           7
`define BIT_OUT_MUTE          3
`define BIT_NOISE_GATE        4
`define BIT_PHONE_MUTE        5

// ----------------------------------------
// gain coding, in half-dB units
// ----------------------------------------
`define LEVEL_BASE_X2         (-93)
`define LEVEL_STEP_X2         3
`define BOOST_X2              24
`define PHONE_BOOST_X2        24
`define SIDETONE_TOP_CODE     4'hA

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ                20000000
`define MS_CYCLES             (`CLK_HZ / 1000)
`define DEBOUNCE_MS_0         0
`define DEBOUNCE_MS_1         8
`define DEBOUNCE_MS_2         16
`define DEBOUNCE_MS_3         32

`endif

/* include/mixer_routing_pkg.sv */
package mixer_routing_pkg;

	typedef struct packed {
		logic              silence;
		logic signed [7:0] gain_db_x2;
	} input_level_t;

	typedef struct packed {
		logic silence;
		logic add_left;
		logic add_right;
		logic add_source;
	} output_route_t;

	typedef struct packed {
		logic       ext_bias_en;
		logic       int_bias_en;
		logic [1:0] bias_code;
		logic       capless_virtual_ground_sel;
	} bias_ctrl_t;

	typedef enum logic [1:0] {
		BTN_IDLE,
		BTN_CHECK,
		BTN_HELD
	} button_state_t;

endpackage

/* verilog/mixer_routing_gain_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mixer_routing_consts.svh"

// Behaviour
// - bit0 picks capless virtual ground level
// - bits 2:1 bias code to chosen output
// - bit3 set means series button type
// - bits 5:4 button debounce 0/8/16/32 ms
// - sidetone code 0 cut, 3 dB steps, saturates
// - phone input level -34.5 to +12 dB
// - phone input bit5 mutes at source
// - left line level, boost adds 12 dB
// - left mute bit6, bit7 picks line source
// - right line level coded like left
// - right mute bit6, bit7 picks line source
// - converter level, boost for both channels
// - bit7 takes converter level codes from line registers
// - phone output adds mic/right/left, bit3 mutes
// - noise gate gates mic to phone output
// - line output adds phone/right/left, bit3 mutes
// - speaker output adds, mutes; bit4 reserved
// - external microphone select steers bias output
module mixer_routing_gain_control #(
	parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	output logic                               reg_hit,
	input  wire logic                          external_microphone_sel,
	input  wire logic                          noise_gate_on,
	input  wire logic                          agc_noise,
	input  wire logic                          dac_zero_cross,
	input  wire logic                          button_raw,
	output mixer_routing_pkg::bias_ctrl_t      bias_ctrl,
	output logic                               button_series,
	output logic                               button_pressed,
	output logic                               monitor_path_cut,
	output logic      [3:0]                    monitor_path_attenuation,
	output mixer_routing_pkg::input_level_t    phone_in,
	output mixer_routing_pkg::input_level_t    left_line_in,
	output mixer_routing_pkg::input_level_t    right_line_in,
	output mixer_routing_pkg::input_level_t    dac_left_in,
	output mixer_routing_pkg::input_level_t    dac_right_in,
	output logic                               left_from_line,
	output logic                               right_from_line,
	output mixer_routing_pkg::output_route_t   phone_output,
	output logic                               phone_mic_gated,
	output mixer_routing_pkg::output_route_t   line_output,
	output mixer_routing_pkg::output_route_t   speaker_output
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] mic_bias_button_config;
	logic [7:0] sidetone_attenuation;
	logic [7:0] phone_input_level;
	logic [7:0] left_line_input_config;
	logic [7:0] right_line_input_config;
	logic [7:0] converter_mixer_level;
	logic [7:0] phone_output_routing;
	logic [7:0] line_output_routing;
	logic [7:0] speaker_output_routing;
	logic       dac_silenced;
	logic [7:0] next_rdata;
	logic       next_hit;

	function automatic logic signed [7:0] level_x2(input logic [4:0] code, input logic boost);
		logic signed [7:0] base;
		base = 8'(`LEVEL_BASE_X2) + 8'(`LEVEL_STEP_X2 * code);
		return boost ? base + 8'(`BOOST_X2) : base;
	endfunction

	// masking on write keeps reserved bits at zero so readback is plain
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mic_bias_button_config  <= `REG_RESET;
			sidetone_attenuation    <= `REG_RESET;
			phone_input_level       <= `REG_RESET;
			left_line_input_config  <= `REG_RESET;
			right_line_input_config <= `REG_RESET;
			converter_mixer_level   <= `REG_RESET;
			phone_output_routing    <= `REG_RESET;
			line_output_routing     <= `REG_RESET;
			speaker_output_routing  <= `REG_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`OFS_MIC_BIAS_BUTTON:  mic_bias_button_config  <= reg_wdata & `MASK_MIC_BIAS_BUTTON;
				`OFS_SIDETONE:         sidetone_attenuation    <= reg_wdata & `MASK_SIDETONE;
				`OFS_PHONE_INPUT:      phone_input_level       <= reg_wdata & `MASK_PHONE_INPUT;
				`OFS_LEFT_LINE_INPUT:  left_line_input_config  <= reg_wdata & `MASK_LINE_INPUT;
				`OFS_RIGHT_LINE_INPUT: right_line_input_config <= reg_wdata & `MASK_LINE_INPUT;
				`OFS_CONVERTER_LEVEL:  converter_mixer_level   <= reg_wdata & `MASK_CONVERTER;
				`OFS_PHONE_OUTPUT:     phone_output_routing    <= reg_wdata & `MASK_PHONE_OUTPUT;
				`OFS_LINE_OUTPUT:      line_output_routing     <= reg_wdata & `MASK_LINE_OUTPUT;
				`OFS_SPEAKER_OUTPUT:   speaker_output_routing  <= reg_wdata & `MASK_SPEAKER_OUTPUT;
				default:               ;
			endcase
		end
	end

	always_comb
	begin
		next_hit = 1'b1;
		case (reg_addr)
			`OFS_MIC_BIAS_BUTTON:  next_rdata = mic_bias_button_config;
			`OFS_SIDETONE:         next_rdata = sidetone_attenuation;
			`OFS_PHONE_INPUT:      next_rdata = phone_input_level;
			`OFS_LEFT_LINE_INPUT:  next_rdata = left_line_input_config;
			`OFS_RIGHT_LINE_INPUT: next_rdata = right_line_input_config;
			`OFS_CONVERTER_LEVEL:  next_rdata = converter_mixer_level;
			`OFS_PHONE_OUTPUT:     next_rdata = phone_output_routing;
			`OFS_LINE_OUTPUT:      next_rdata = line_output_routing;
			`OFS_SPEAKER_OUTPUT:   next_rdata = speaker_output_routing;
			default:
			begin
				next_rdata = 8'h00;
				next_hit   = 1'b0;
			end
		endcase
	end

	// read data is registered: valid the edge after reg_rd, unmapped reads zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
		end
		else if (reg_rd)
		begin
			reg_rdata <= next_rdata;
			reg_hit   <= next_hit;
		end
	end

	// ----------------------------------------
	// microphone bias and headphone common node
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bias_ctrl <= '0;
		else
		begin
			bias_ctrl.capless_virtual_ground_sel <= mic_bias_button_config[`BIT_VCM_SEL];
			bias_ctrl.bias_code                  <= mic_bias_button_config[2:1];
			bias_ctrl.ext_bias_en                <= external_microphone_sel;
			bias_ctrl.int_bias_en                <= !external_microphone_sel;
		end
	end

	// ----------------------------------------
	// parallel button debounce
	// ----------------------------------------
	// a 1 ms tick keeps the debounce counter narrow; the cost is up to 1 ms of jitter
	logic [$clog2(MS_CYCLES)-1:0]  ms_div;
	logic                          ms_tick;
	logic [5:0]                    ms_left;
	logic [5:0]                    debounce_ms;
	mixer_routing_pkg::button_state_t btn_state;

	assign ms_tick = (ms_div == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ms_div <= '0;
		else if (ms_tick)
			ms_div <= '0;
		else
			ms_div <= ms_div + 1'b1;
	end

	always_comb
	begin
		case (mic_bias_button_config[5:4])
			2'b00:   debounce_ms = 6'(`DEBOUNCE_MS_0);
			2'b01:   debounce_ms = 6'(`DEBOUNCE_MS_1);
			2'b10:   debounce_ms = 6'(`DEBOUNCE_MS_2);
			default: debounce_ms = 6'(`DEBOUNCE_MS_3);
		endcase
	end

	assign button_series = mic_bias_button_config[`BIT_BUTTON_SERIES];

	// series buttons are debounced by the headset-detect timer elsewhere, so they pass raw
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			btn_state      <= mixer_routing_pkg::BTN_IDLE;
			ms_left        <= '0;
			button_pressed <= 1'b0;
		end
		else if (button_series)
		begin
			btn_state      <= mixer_routing_pkg::BTN_IDLE;
			button_pressed <= button_raw;
		end
		else
		begin
			case (btn_state)
				mixer_routing_pkg::BTN_IDLE:
				begin
					button_pressed <= 1'b0;
					ms_left        <= debounce_ms;
					if (button_raw)
						btn_state <= mixer_routing_pkg::BTN_CHECK;
				end
				mixer_routing_pkg::BTN_CHECK:
				begin
					if (!button_raw)
						btn_state <= mixer_routing_pkg::BTN_IDLE;
					else if (ms_left == 6'd0)
					begin
						btn_state      <= mixer_routing_pkg::BTN_HELD;
						button_pressed <= 1'b1;
					end
					else if (ms_tick)
						ms_left <= ms_left - 6'd1;
				end
				mixer_routing_pkg::BTN_HELD:
				begin
					if (!button_raw)
						btn_state <= mixer_routing_pkg::BTN_IDLE;
				end
				default: btn_state <= mixer_routing_pkg::BTN_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// input levels and sources
	// ----------------------------------------
	logic [7:0] dac_left_src;
	logic [7:0] dac_right_src;

	// with balance on, the converter follows the line level codes
	assign dac_left_src  = converter_mixer_level[`BIT_SRC_SEL] ? left_line_input_config : converter_mixer_level;
	assign dac_right_src = converter_mixer_level[`BIT_SRC_SEL] ? right_line_input_config : converter_mixer_level;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dac_silenced <= 1'b0;
		else if (dac_zero_cross)
			dac_silenced <= converter_mixer_level[`BIT_MUTE_IN];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			monitor_path_cut         <= 1'b1;
			monitor_path_attenuation <= 4'h0;
			phone_in                 <= '0;
			left_line_in             <= '0;
			right_line_in            <= '0;
			dac_left_in              <= '0;
			dac_right_in             <= '0;
			left_from_line           <= 1'b0;
			right_from_line          <= 1'b0;
		end
		else
		begin
			monitor_path_cut         <= (sidetone_attenuation[3:0] == 4'h0);
			monitor_path_attenuation <= (sidetone_attenuation[3:0] > `SIDETONE_TOP_CODE) ?
				`SIDETONE_TOP_CODE : sidetone_attenuation[3:0];
			phone_in.silence         <= phone_input_level[`BIT_PHONE_MUTE];
			phone_in.gain_db_x2      <= level_x2(phone_input_level[4:0], 1'b1);
			left_line_in.silence     <= left_line_input_config[`BIT_MUTE_IN];
			left_line_in.gain_db_x2  <= level_x2(left_line_input_config[4:0],
				left_line_input_config[`BIT_BOOST]);
			right_line_in.silence    <= right_line_input_config[`BIT_MUTE_IN];
			right_line_in.gain_db_x2 <= level_x2(right_line_input_config[4:0],
				right_line_input_config[`BIT_BOOST]);
			dac_left_in.silence      <= dac_silenced;
			dac_right_in.silence     <= dac_silenced;
			dac_left_in.gain_db_x2   <= level_x2(dac_left_src[4:0], converter_mixer_level[`BIT_BOOST]);
			dac_right_in.gain_db_x2  <= level_x2(dac_right_src[4:0], converter_mixer_level[`BIT_BOOST]);
			left_from_line           <= left_line_input_config[`BIT_SRC_SEL];
			right_from_line          <= right_line_input_config[`BIT_SRC_SEL];
		end
	end

	// ----------------------------------------
	// output routing
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phone_output    <= '0;
			line_output     <= '0;
			speaker_output  <= '0;
			phone_mic_gated <= 1'b0;
		end
		else
		begin
			phone_output    <= {phone_output_routing[`BIT_OUT_MUTE], phone_output_routing[2:0]};
			line_output     <= {line_output_routing[`BIT_OUT_MUTE], line_output_routing[2:0]};
			speaker_output  <= {speaker_output_routing[`BIT_OUT_MUTE], speaker_output_routing[2:0]};
			phone_mic_gated <= phone_output_routing[`BIT_NOISE_GATE] && noise_gate_on && agc_noise;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_readback;
		reg_wr && reg_addr == `OFS_CONVERTER_LEVEL ##1 reg_rd && !reg_wr && reg_addr == `OFS_CONVERTER_LEVEL
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (@(posedge clk) disable iff (!rst_n) p_readback) else $error("readback mismatch");

	property p_spk_reserved;
		reg_rd ##1 1'b1 |-> reg_rdata[4] == 1'b0 || $past(reg_addr) != `OFS_SPEAKER_OUTPUT;
	endproperty
	a_spk_reserved: assert property (@(posedge clk) disable iff (!rst_n) p_spk_reserved) else $error("reserved bit set");

	property p_unmapped;
		reg_rd && reg_addr > `OFS_SPEAKER_OUTPUT |=> !reg_hit && reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (@(posedge clk) disable iff (!rst_n) p_unmapped) else $error("unmapped read not zero");

	property p_dac_mute_waits;
		!dac_zero_cross && !dac_silenced |=> !dac_silenced;
	endproperty
	a_dac_mute_waits: assert property (@(posedge clk) disable iff (!rst_n) p_dac_mute_waits) else $error("mute without zero crossing");

	property p_dac_mute_takes;
		dac_zero_cross && converter_mixer_level[`BIT_MUTE_IN] |=> ##1 dac_left_in.silence && dac_right_in.silence;
	endproperty
	a_dac_mute_takes: assert property (@(posedge clk) disable iff (!rst_n) p_dac_mute_takes) else $error("dac mute late");

	property p_gate;
		phone_output_routing[`BIT_NOISE_GATE] && noise_gate_on && agc_noise |=> phone_mic_gated;
	endproperty
	a_gate: assert property (@(posedge clk) disable iff (!rst_n) p_gate) else $error("noise gate missed");

	property p_bias_steer;
		external_microphone_sel |=> bias_ctrl.ext_bias_en && !bias_ctrl.int_bias_en;
	endproperty
	a_bias_steer: assert property (@(posedge clk) disable iff (!rst_n) p_bias_steer) else $error("bias not steered");

	property p_sidetone_sat;
		sidetone_attenuation[3:0] >= 4'hB |=> monitor_path_attenuation == 4'hA && !monitor_path_cut;
	endproperty
	a_sidetone_sat: assert property (@(posedge clk) disable iff (!rst_n) p_sidetone_sat) else $error("sidetone not 0 dB");

	property p_phone_top;
		phone_input_level[4:0] == 5'h1F |=> phone_in.gain_db_x2 == 8'sd24;
	endproperty
	a_phone_top: assert property (@(posedge clk) disable iff (!rst_n) p_phone_top) else $error("phone gain top wrong");

	property p_line_floor;
		// rst_n in the antecedent: the edge that releases reset still leaves the outputs at reset
		rst_n && left_line_input_config[5:0] == 6'h00 |=> left_line_in.gain_db_x2 == -8'sd93;
	endproperty
	a_line_floor: assert property (@(posedge clk) disable iff (!rst_n) p_line_floor) else $error("line gain floor wrong");

	property p_zero_debounce;
		!button_series && btn_state == mixer_routing_pkg::BTN_IDLE && button_raw && debounce_ms == 6'd0
			##1 button_raw |=> button_pressed;
	endproperty
	a_zero_debounce: assert property (@(posedge clk) disable iff (!rst_n) p_zero_debounce) else $error("debounce slow");

	c_balance: cover property (@(posedge clk) disable iff (!rst_n) converter_mixer_level[`BIT_SRC_SEL] && reg_wr);
	c_dac_mute: cover property (@(posedge clk) disable iff (!rst_n) $rose(dac_silenced));
	c_button: cover property (@(posedge clk) disable iff (!rst_n) $rose(button_pressed) && !button_series);
	c_gate: cover property (@(posedge clk) disable iff (!rst_n) $rose(phone_mic_gated));

endmodule
`default_nettype wire

/* tb/mixer_routing_gain_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mixer_routing_consts.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("[ERR] %s expected %0h seen %0h", what, exp, got); end end

module mixer_routing_gain_control_tb_top;
	// short millisecond so the 32 ms debounce stays 128 cycles
	localparam int MS = 4;

	logic                             clk;
	logic                             rst_n;
	logic [7:0]                       reg_addr;
	logic [7:0]                       reg_wdata;
	logic                             reg_wr;
	logic                             reg_rd;
	logic [7:0]                       reg_rdata;
	logic                             reg_hit;
	logic                             external_microphone_sel;
	logic                             noise_gate_on;
	logic                             agc_noise;
	logic                             dac_zero_cross;
	logic                             button_raw;
	mixer_routing_pkg::bias_ctrl_t    bias_ctrl;
	logic                             button_series;
	logic                             button_pressed;
	logic                             monitor_path_cut;
	logic [3:0]                       monitor_path_attenuation;
	mixer_routing_pkg::input_level_t  phone_in;
	mixer_routing_pkg::input_level_t  left_line_in;
	mixer_routing_pkg::input_level_t  right_line_in;
	mixer_routing_pkg::input_level_t  dac_left_in;
	mixer_routing_pkg::input_level_t  dac_right_in;
	logic                             left_from_line;
	logic                             right_from_line;
	mixer_routing_pkg::output_route_t phone_output;
	logic                             phone_mic_gated;
	mixer_routing_pkg::output_route_t line_output;
	mixer_routing_pkg::output_route_t speaker_output;
	int                               n_errors = 0;
	int                               check_count = 0;

	mixer_routing_gain_control #(.MS_CYCLES(MS)) dut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.external_microphone_sel(external_microphone_sel), .noise_gate_on(noise_gate_on),
		.agc_noise(agc_noise), .dac_zero_cross(dac_zero_cross), .button_raw(button_raw),
		.bias_ctrl(bias_ctrl), .button_series(button_series), .button_pressed(button_pressed),
		.monitor_path_cut(monitor_path_cut), .monitor_path_attenuation(monitor_path_attenuation),
		.phone_in(phone_in), .left_line_in(left_line_in), .right_line_in(right_line_in),
		.dac_left_in(dac_left_in), .dac_right_in(dac_right_in), .left_from_line(left_from_line),
		.right_from_line(right_from_line), .phone_output(phone_output), .phone_mic_gated(phone_mic_gated),
		.line_output(line_output), .speaker_output(speaker_output)
	);

	always #25 clk = ~clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic mixer_routing_pkg::input_level_t lvl(input logic s, input int g);
		mixer_routing_pkg::input_level_t r;
		r.silence = s;
		r.gain_db_x2 = g[7:0];
		return r;
	endfunction

	function automatic int gain(input int code, input int boost);
		return `LEVEL_BASE_X2 + `LEVEL_STEP_X2 * code + `BOOST_X2 * boost;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// derived outputs are registered behind the register: let them land
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp_d, input logic exp_hit);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("reg_rdata", exp_d, reg_rdata)
		`CHK("reg_hit", exp_hit, reg_hit)
	endtask

	// write then read in back-to-back cycles: the read must see the new value
	task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("reg_rdata", d, reg_rdata)
	endtask

	task automatic pulse_zero_cross();
		@(posedge clk);
		dac_zero_cross <= 1'b1;
		@(posedge clk);
		dac_zero_cross <= 1'b0;
		settle();
	endtask

	// bounded wait; a run-out counts as a mismatch and ends the run
	task automatic wait_press(output int n);
		n = 0;
		while (button_pressed !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 400)
		begin
			n_errors++;
			$display("[ERR] button_pressed expected 1 seen timeout");
			summarize();
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [7:0] ofs [9] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
		logic [7:0] msk [9] = '{8'h3F, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h0F, 8'h0F};
		`CHK("monitor_path_cut", 1'b1, monitor_path_cut)
		for (int i = 0; i < 9; i++)
			rd_chk(ofs[i], 8'h00, 1'b1);
		for (int i = 0; i < 9; i++)
		begin
			wr(ofs[i], 8'hFF);
			rd_chk(ofs[i], msk[i], 1'b1);
		end
		wr_rd_chk(8'h11, 8'h5A);
		wr(8'h15, 8'hA5);
		rd_chk(8'h15, 8'h00, 1'b0);
		rd_chk(8'h0B, 8'h00, 1'b0);
	endtask

	task automatic t_bias();
		// sidetone held cut while the microphone selection moves
		wr(8'h0D, 8'h00);
		settle();
		`CHK("monitor_path_cut", 1'b1, monitor_path_cut)
		for (int e = 0; e < 2; e++)
			for (int c = 0; c < 4; c++)
			begin
				@(posedge clk);
				external_microphone_sel <= e[0];
				// the bench stands for a supply above the threshold, so code 11 is allowed
				wr(8'h0C, {4'h0, c[0], c[1:0], ~c[0]});
				settle();
				`CHK("bias_ctrl", {e[0], ~e[0], c[1:0], ~c[0]}, bias_ctrl)
				`CHK("button_series", c[0], button_series)
			end
	endtask

	task automatic t_sidetone();
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h0D, 8'hF0 | i[7:0]);
			settle();
			`CHK("monitor_path_cut", (i == 0), monitor_path_cut)
			`CHK("monitor_path_attenuation", ((i > 10) ? 4'hA : i[3:0]), monitor_path_attenuation)
		end
	endtask

	task automatic t_gains();
		wr(8'h0E, 8'h00);
		wr(8'h0F, 8'h3F);
		wr(8'h10, 8'h25);
		wr(8'h11, 8'h25);
		settle();
		`CHK("phone_in", lvl(0, gain(0, 1)), phone_in)
		`CHK("left_line_in", lvl(0, 24), left_line_in)
		`CHK("right_line_in", lvl(0, gain(5, 1)), right_line_in)
		`CHK("dac_left_in", lvl(0, gain(5, 1)), dac_left_in)
		`CHK("dac_right_in", lvl(0, gain(5, 1)), dac_right_in)
		wr(8'h0E, 8'h3F);
		wr(8'h0F, 8'hCA);
		wr(8'h10, 8'h54);
		wr(8'h11, 8'hA0);
		settle();
		`CHK("phone_in", lvl(1, 24), phone_in)
		`CHK("left_line_in", lvl(1, gain(10, 0)), left_line_in)
		`CHK("left_from_line", 1'b1, left_from_line)
		`CHK("right_line_in", lvl(1, gain(20, 0)), right_line_in)
		`CHK("right_from_line", 1'b0, right_from_line)
		`CHK("dac_left_in", lvl(0, gain(10, 1)), dac_left_in)
		`CHK("dac_right_in", lvl(0, gain(20, 1)), dac_right_in)
		wr(8'h10, 8'h80);
		settle();
		`CHK("right_from_line", 1'b1, right_from_line)
	endtask

	task automatic t_zero_cross();
		wr(8'h11, 8'h40);
		settle();
		`CHK("dac_left_in.silence", 1'b0, dac_left_in.silence)
		pulse_zero_cross();
		`CHK("dac_left_in.silence", 1'b1, dac_left_in.silence)
		`CHK("dac_right_in.silence", 1'b1, dac_right_in.silence)
		wr(8'h11, 8'h00);
		settle();
		`CHK("dac_right_in.silence", 1'b1, dac_right_in.silence)
		pulse_zero_cross();
		`CHK("dac_right_in.silence", 1'b0, dac_right_in.silence)
	endtask

	task automatic t_routing();
		for (int v = 0; v < 16; v++)
		begin
			wr(8'h12, v[7:0]);
			wr(8'h13, 8'h0F ^ v[7:0]);
			wr(8'h14, 8'h10 | v[7:0]);
			settle();
			`CHK("phone_output", v[3:0], phone_output)
			`CHK("line_output", 4'hF ^ v[3:0], line_output)
			`CHK("speaker_output", v[3:0], speaker_output)
		end
		for (int g = 0; g < 8; g++)
		begin
			wr(8'h12, {3'h0, g[2], 4'h1});
			@(posedge clk);
			noise_gate_on <= g[1];
			agc_noise <= g[0];
			settle();
			`CHK("phone_mic_gated", (g == 7), phone_mic_gated)
		end
	endtask

	task automatic t_button();
		int n;
		int ms [4] = '{0, 8, 16, 32};
		wr(8'h08 + 8'h04, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h0C, {2'b00, c[1:0], 4'h0});
			settle();
			@(posedge clk);
			button_raw <= 1'b1;
			// a short release halfway through must restart the count
			if (c != 0)
			begin
				repeat (ms[c] * MS / 2) @(posedge clk);
				button_raw <= 1'b0;
				repeat (2) @(posedge clk);
				button_raw <= 1'b1;
			end
			#1;
			wait_press(n);
			`CHK("debounce_low", 1'b1, n >= (ms[c] - 1) * MS)
			`CHK("debounce_high", 1'b1, n <= ms[c] * MS + MS + 4)
			@(posedge clk);
			button_raw <= 1'b0;
			settle();
			`CHK("button_pressed", 1'b0, button_pressed)
		end
		wr(8'h0C, 8'h38);
		settle();
		@(posedge clk);
		button_raw <= 1'b1;
		settle();
		`CHK("button_pressed", 1'b1, button_pressed)
		@(posedge clk);
		button_raw <= 1'b0;
		settle();
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		external_microphone_sel = 1'b0;
		noise_gate_on = 1'b0;
		agc_noise = 1'b0;
		dac_zero_cross = 1'b0;
		button_raw = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_regs();
		t_bias();
		t_sidetone();
		t_gains();
		t_zero_cross();
		t_routing();
		t_button();
		summarize();
	end
endmodule
`default_nettype wire
